// File: hdl/isp_pkg.sv
// constants shared by the serial programming port
// assumes a 100 MHz system clock sampling the programmer's pins
package isp_pkg;
  localparam logic [7:0] CMD_ENABLE = 8'hac;
  localparam logic [7:0] SUB_ENABLE = 8'h53;
  localparam logic [2:0] SUB_ERASE = 3'h4;
  localparam logic [3:0] SUB_FUSE = 4'h1;
  localparam logic [4:0] SUB_LOCK = 5'h1c;
  localparam logic [7:0] CMD_RD_FUSE = 8'h21;
  localparam logic [7:0] CMD_RD_LOCK = 8'h24;
  localparam logic [7:0] CMD_WR_SIG_BYTE = 8'h42;
  localparam logic [7:0] CMD_RD_SIG_BYTE = 8'h22;
  localparam logic [7:0] CMD_WR_SIG_PAGE = 8'h52;
  localparam logic [7:0] CMD_RD_SIG_PAGE = 8'h32;
  localparam int HEADER_BYTES = 3;
  localparam int BYTE_PACKET = 4;
  localparam int PAGE_PACKET = 35;
  localparam int PAGE_BYTES = 32;
  localparam int FUSE_ISP_BIT = 0;
  localparam int FUSE_X2_BIT = 1;
  localparam int FUSE_ROW_BIT = 2;
  localparam int FUSE_BYPASS_BIT = 3;
  localparam int LOCK1_BIT = 0;
  localparam int LOCK2_BIT = 1;
  localparam logic [3:0] FUSE_RESET = 4'h0;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage : isp_pkg

// File: hdl/isp_sig_row.sv
// user signature row: 32 bytes, registered read data
// assumes one write or read port on the system clock
`timescale 1ns/1ps
`default_nettype none
module isp_sig_row
  import isp_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clock_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic erase_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);
  if (DEPTH > (1 << AW)) begin : g_depth_check
    $error("depth exceeds address range");
  end
  logic [7:0] mem [DEPTH];
  // one write decoder per entry; erase wins over a write in the same cycle
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock_in) begin
      if (erase_in) begin
        mem[i] <= ERASED_BYTE;
      end else if (we_in && waddr_in == AW'(i)) begin
        mem[i] <= wdata_in;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    rdata_out <= mem[raddr_in];
  end
endmodule : isp_sig_row
`default_nettype wire

// File: hdl/isp_serial_port.sv
// serial programming port: shifts fixed-length command packets on the link
// assumes sck, mosi and reset pin are asynchronous and sck is well below clock/8
// Operation
// - signature byte write, 0x42, offset byte three
// - signature byte read, 0x22, data in byte four
// - signature page write, 0x52, 32 data bytes
// - signature page read, 0x32, bytes in order
// - fuse byte: four active-low enables, bits 0-3
// - isp fuse clearing waits for reset low
// - bypass fuse change needs power cycle
// - lock byte: two active-low lock bits
// - bytes shift most significant bit first
// - output data changes on sck rising edge
// - input data sampled on sck falling edge
// - byte commands are four bytes long
// - page commands are thirty-five bytes long
`timescale 1ns/1ps
`default_nettype none
module isp_serial_port
  import isp_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic power_up_in,
  input wire logic rst_pin_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic prog_mode_out,
  output logic prog_enabled_out,
  output logic [3:0] fuse_active_out,
  output logic [1:0] lock_out,
  output logic erase_pulse_out
);
  typedef enum logic [1:0] {IDLE, LOCKED_OUT, ACTIVE} mode_e;
  // synchronisers, link engine and fuse/lock state live in one register
  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic sck_d;
    mode_e mode;
    logic enabled;
    logic [2:0] bit_cnt;
    logic [5:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] tx;
    logic miso;
    logic [3:0] fuse;
    logic [3:0] fuse_act;
    logic [1:0] lock;
    logic erase;
  } state_s;
  state_s st;
  state_s next_st;
  // ==========================================================
  // row port and decode helpers
  logic [7:0] rd_data;
  logic we;
  logic [4:0] waddr;
  logic [4:0] raddr;
  logic [7:0] rx_byte;
  logic [5:0] pkt_len;
  // ==========================================================
  // signature row
  isp_sig_row #(.DEPTH(PAGE_BYTES), .AW(5)) u_row (
    .clock_in(clock_in),
    .we_in(we),
    .waddr_in(waddr),
    .wdata_in(rx_byte),
    .erase_in(st.erase),
    .raddr_in(raddr),
    .rdata_out(rd_data)
  );
  // ==========================================================
  // next state
  always_comb begin
    logic rise;
    logic fall;
    logic last_bit;
    logic [7:0] nb;
    // edges seen on the synchronised link clock, one cycle late via sck_d
    rise = st.sck_s[1] && !st.sck_d;
    fall = !st.sck_s[1] && st.sck_d;
    last_bit = st.bit_cnt == 3'h7;
    nb = {st.shift[6:0], st.mosi_s[1]};
    next_st = st;
    next_st.rst_s = {st.rst_s[0], rst_pin_in};
    next_st.sck_s = {st.sck_s[0], sck_in};
    next_st.mosi_s = {st.mosi_s[0], mosi_in};
    next_st.sck_d = st.sck_s[1];
    next_st.erase = 1'b0;
    we = 1'b0;
    waddr = 5'(st.byte_cnt - 6'(HEADER_BYTES));
    // a single byte read addresses the row by the offset in header byte three
    if (st.cmd == CMD_RD_SIG_BYTE) begin
      raddr = st.b3[4:0];
    end else begin
      raddr = 5'(st.byte_cnt - 6'(HEADER_BYTES - 1));
    end
    rx_byte = nb;
    pkt_len = (st.cmd[4] && st.cmd != CMD_ENABLE) ? 6'(PAGE_PACKET) : 6'(BYTE_PACKET);
    // a power cycle reloads every fuse, the only way besides synchronous reset that the bypass bit changes
    if (power_up_in) begin
      next_st.fuse_act = st.fuse;
    end
    // ==========================================================
    // mode sequencing and the byte engine
    case (st.mode)
      IDLE: begin
        next_st.miso = 1'b0;
        // entry needs the link clock low so the first rise is a real bit
        if (st.rst_s[1] && !st.sck_s[1]) begin
          next_st.mode = st.fuse_act[FUSE_ISP_BIT] ? LOCKED_OUT : ACTIVE;
          next_st.enabled = 1'b0;
          next_st.bit_cnt = 3'h0;
          next_st.byte_cnt = 6'h0;
        end
      end
      LOCKED_OUT: begin
        // isp fuse disabled: ignore the link until the pin drops
        if (!st.rst_s[1]) next_st.mode = IDLE;
      end
      default: begin
        if (!st.rst_s[1]) begin
          next_st.mode = IDLE;
          // a new session must send program enable again
          next_st.enabled = 1'b0;
          next_st.fuse_act = {st.fuse_act[FUSE_BYPASS_BIT], st.fuse[2:0]};
        end else if (rise) begin
          next_st.miso = st.tx[7];
          next_st.tx = {st.tx[6:0], 1'b0};
          // the addressed byte is fetched after the offset byte ends, so load it on the first rise
          if (st.cmd == CMD_RD_SIG_BYTE && st.byte_cnt == 6'(HEADER_BYTES) && st.bit_cnt == 3'h0
              && st.enabled && st.lock[LOCK2_BIT]) begin
            next_st.miso = rd_data[7];
            next_st.tx = {rd_data[6:0], 1'b0};
          end
        end else if (fall) begin
          next_st.shift = nb;
          next_st.bit_cnt = st.bit_cnt + 3'h1;
          if (last_bit) begin
            next_st.byte_cnt = st.byte_cnt + 6'h1;
            next_st.tx = 8'h00;
            if (st.byte_cnt == 6'h0) next_st.cmd = nb;
            if (st.byte_cnt == 6'h1) next_st.b2 = nb;
            if (st.byte_cnt == 6'h2) begin
              next_st.b3 = nb;
              if (st.cmd == CMD_RD_FUSE || st.cmd == CMD_RD_LOCK) begin
                next_st.tx = (st.cmd == CMD_RD_FUSE) ? {4'h0, st.fuse} : {6'h0, st.lock};
              end
            end
            // lock bit 2 guards reading the row, lock bit 1 guards writing it
            if (st.byte_cnt >= 6'h2 && st.enabled && st.lock[LOCK2_BIT]) begin
              if (st.cmd == CMD_RD_SIG_PAGE && st.byte_cnt < 6'(PAGE_PACKET - 1)) next_st.tx = rd_data;
            end
            // row writes need the row fuse enabled and lock bit 1 open
            if (st.byte_cnt >= 6'(HEADER_BYTES) && st.enabled && !st.fuse_act[FUSE_ROW_BIT]
                && st.lock[LOCK1_BIT]) begin
              if (st.cmd == CMD_WR_SIG_PAGE) we = 1'b1;
              if (st.cmd == CMD_WR_SIG_BYTE) begin
                we = 1'b1;
                waddr = st.b3[4:0];
              end
            end
            // packet end: erase, fuse and lock writes act only here
            if (st.byte_cnt == pkt_len - 6'h1) begin
              next_st.byte_cnt = 6'h0;
              if (st.cmd == CMD_ENABLE) begin
                if (st.b2 == SUB_ENABLE) next_st.enabled = 1'b1;
                else if (st.enabled && st.b2[7:5] == SUB_ERASE) begin
                  next_st.erase = 1'b1;
                  next_st.lock = LOCK_RESET;
                end else if (st.enabled && st.b2[7:4] == SUB_FUSE) next_st.fuse = st.b2[3:0];
                else if (st.enabled && st.b2[7:3] == SUB_LOCK) next_st.lock = st.lock & st.b2[1:0];
              end
            end
          end
        end
      end
    endcase
    // synchronous reset overrides mode, counters, miso, tx, erase, fuse and lock; the row write strobe is not reset
    if (!resetn_in) begin
      next_st.mode = IDLE;
      next_st.enabled = 1'b0;
      next_st.bit_cnt = 3'h0;
      next_st.byte_cnt = 6'h0;
      next_st.miso = 1'b0;
      next_st.tx = 8'h00;
      next_st.erase = 1'b0;
      next_st.fuse = FUSE_RESET;
      next_st.fuse_act = FUSE_RESET;
      next_st.lock = LOCK_RESET;
    end
  end
  // ==========================================================
  // state register and outputs
  always_ff @(posedge clock_in) begin
    st <= next_st;
  end
  assign miso_out = st.miso;
  assign miso_oe_out = st.mode == ACTIVE;
  assign prog_mode_out = st.mode == ACTIVE;
  assign prog_enabled_out = st.enabled;
  assign fuse_active_out = st.fuse_act;
  assign lock_out = st.lock;
  assign erase_pulse_out = st.erase;
endmodule : isp_serial_port
`default_nettype wire

// File: tb/isp_port_chk.sv
// checker for the serial programming port
// assumes a bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module isp_port_chk (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic power_up_in,
  input wire logic rst_pin_in,
  input wire logic sck_in,
  input wire logic miso_out,
  input wire logic miso_oe_out,
  input wire logic prog_mode_out,
  input wire logic prog_enabled_out,
  input wire logic [3:0] fuse_active_out,
  input wire logic [1:0] lock_out,
  input wire logic erase_pulse_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence pin_low;
    !rst_pin_in [*6];
  endsequence
  chk_oe_off: assert property (pin_low |=> !miso_oe_out)
    else $error("miso driven");
  chk_mode_off: assert property (pin_low |=> !prog_mode_out)
    else $error("mode held");
  chk_miso_rise: assert property ($fell(sck_in) |-> $stable(miso_out) [*6])
    else $error("miso moved");
  chk_enable_mode: assert property (!prog_mode_out [*2] |-> !prog_enabled_out)
    else $error("enable no mode");
  chk_isp_hold: assert property (rst_pin_in && $past(rst_pin_in) |-> $stable(fuse_active_out[0]))
    else $error("isp fuse early");
  chk_bypass_wait: assert property ($changed(fuse_active_out[3]) |-> $past(power_up_in))
    else $error("bypass early");
  chk_lock_en: assert property ($changed(lock_out) |-> $past(prog_enabled_out))
    else $error("lock moved");
  chk_erase_lock: assert property (erase_pulse_out |-> ##[0:2] (lock_out == 2'h3))
    else $error("erase lock");
endmodule : isp_port_chk
`default_nettype wire

// File: tb/isp_prog_model.sv
// programmer model: bit-bangs the link, 160 ns per sck period
// assumes the 100 MHz bench clock
`timescale 1ns/1ps
`default_nettype none
module isp_prog_model (
  input wire logic clock_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic rst_pin_out
);
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    rst_pin_out = 1'b0;
  end
  task automatic enter();
    repeat (1000) @(posedge clock_in);
    rst_pin_out <= 1'b1;
    repeat (20) @(posedge clock_in); // settling wait shortened
  endtask : enter
  task automatic leave();
    rst_pin_out <= 1'b0;
    @(posedge clock_in);
    mosi_out <= ~mosi_out; // toggled, not released
    repeat (10) @(posedge clock_in);
  endtask : leave
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock_in);
      mosi_out <= tx[i];
      sck_out <= 1'b1;
      repeat (8) @(posedge clock_in);
      rx[i] = miso_in;
      sck_out <= 1'b0;
      repeat (7) @(posedge clock_in);
    end
  endtask : xfer
endmodule : isp_prog_model
`default_nettype wire

// File: tb/isp_serial_program_port_tb_top.sv
// bench top: port, programmer model, checker
// assumes design and model compiled first
`timescale 1ns/1ps
`default_nettype none
module isp_serial_program_port_tb_top;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic power_up_in = 1'b0;
  wire logic sck, mosi, rst_pin, miso, oe, mode, en;
  wire logic [3:0] fuse;
  wire logic [1:0] lock;
  wire logic erase;
  int erase_seen = 0;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] r;
  always #5 clock_in = ~clock_in;
  isp_serial_port dut_u (.clock_in, .resetn_in, .power_up_in, .rst_pin_in(rst_pin), .sck_in(sck),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(oe), .prog_mode_out(mode), .prog_enabled_out(en),
    .fuse_active_out(fuse), .lock_out(lock), .erase_pulse_out(erase));
  isp_prog_model pm_u (.clock_in, .miso_in(miso), .sck_out(sck), .mosi_out(mosi), .rst_pin_out(rst_pin));
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic pkt(input logic [31:0] c);
    for (int i = 3; i >= 0; i--) pm_u.xfer(c[i*8+:8], r);
  endtask : pkt
  // 3 header bytes then 32 data bytes, offset k carries k+16
  task automatic page(input logic [7:0] op);
    for (int i = 0; i < 35; i++) begin
      pm_u.xfer(i == 0 ? op : (i < 3 ? 8'h0 : 8'(i + 13)), r);
      if (op == 8'h32 && i > 2) check(r, 8'(i + 13));
    end
  endtask : page
  task automatic t_enable();
    pm_u.enter();
    check(8'(mode), 8'h1);
    check(8'(oe), 8'h1);
    pkt(32'hac530000);
    check(8'(en), 8'h1);
    pkt(32'h21000000);
    check({4'h0, r[3:0]}, 8'h0);
  endtask : t_enable
  task automatic t_bytes();
    pkt(32'hac800000);
    check(8'(lock), 8'h3);
    check(8'(erase_seen), 8'h1);
    pkt(32'h22000700);
    check(r, 8'hff);
    pkt(32'h420005a5);
    pkt(32'h22000500);
    check(r, 8'ha5);
  endtask : t_bytes
  task automatic t_page();
    page(8'h52);
    page(8'h32);
    pkt(32'h22001f00);
    check(r, 8'h2f);
  endtask : t_page
  task automatic t_lock();
    pkt(32'hace20000);
    check(8'(lock), 8'h2);
    pkt(32'h24000000);
    check({6'h0, r[1:0]}, 8'h2);
    pkt(32'h42000500);
    pkt(32'h22000500);
    check(r, 8'h15);
  endtask : t_lock
  // row fuse disabled for one session: a signature write must be refused
  task automatic t_row();
    pkt(32'hac140000);
    pm_u.leave();
    check({4'h0, fuse}, 8'h4);
    check(8'(en), 8'h0);
    pm_u.enter();
    pkt(32'hac530000);
    check(8'(en), 8'h1);
    pkt(32'hac800000);
    pkt(32'h42000677);
    pkt(32'h22000600);
    check(r, 8'hff);
  endtask : t_row
  task automatic t_fuse();
    pkt(32'hac190000);
    check({4'h0, fuse}, 8'h4);
    pm_u.leave();
    check({4'h0, fuse}, 8'h1);
    check(8'(oe), 8'h0);
    power_up_in <= 1'b1;
    @(posedge clock_in);
    power_up_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    check({4'h0, fuse}, 8'h9);
    pm_u.enter();
    check(8'(mode), 8'h0);
  endtask : t_fuse
  always @(posedge clock_in) begin
    if (erase) erase_seen <= erase_seen + 1;
  end
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_enable();
    t_bytes();
    t_page();
    t_lock();
    t_row();
    t_fuse();
    close_out();
  end
endmodule : isp_serial_program_port_tb_top
bind isp_serial_port isp_port_chk chk_u (.clock_in, .resetn_in, .power_up_in, .rst_pin_in, .sck_in,
  .miso_out, .miso_oe_out, .prog_mode_out, .prog_enabled_out, .fuse_active_out, .lock_out, .erase_pulse_out);
`default_nettype wire
